// *** design/pin_change_interrupt.sv ***
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ns
// Pin change interrupt unit with per-pin edge enables and sticky flags
module pin_change_interrupt (
  input  wire logic       sys_clk,              // System clock, 100 MHz
  input  wire logic       rst,                  // Async reset, active high
  input  wire logic [7:0] port_a_pins,          // Port A pins
  input  wire logic [7:0] port_b_pins,          // Port B pins
  input  wire logic [7:0] port_c_pins,          // Port C pins
  input  wire logic [3:0] port_e_pins,          // Port E low pins
  input  wire logic       sleep_mode,           // Device is asleep
  input  wire logic [4:0] reg_addr,             // Register address
  input  wire logic [7:0] reg_wdata,            // Write data
  input  wire logic       reg_wr,               // Write strobe
  input  wire logic       reg_rd,               // Read strobe
  output logic      [7:0] reg_rdata,            // Read data, cycle after strobe
  output logic            change_irq,           // Interrupt request level
  output logic            wake_req,             // Wake from sleep level
  output logic            change_summary_flag,  // OR of all pin flags
  output logic            change_irq_enable     // Master enable state
);

  localparam int NP = pin_change_pkg::NUM_PORTS;
  localparam int PW = pin_change_pkg::PORT_W;

  typedef struct packed {
    logic [NP-1:0][PW-1:0] rise_enable_reg;
    logic [NP-1:0][PW-1:0] fall_enable_reg;
    logic [NP-1:0][PW-1:0] change_flag_reg;
    logic                  irq_en;
    logic                  unit_dis;
    logic [PW-1:0]         rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [NP-1:0][PW-1:0] pins_all;
  logic [NP-1:0][PW-1:0] rise_ev;
  logic [NP-1:0][PW-1:0] fall_ev;
  logic [NP-1:0][PW-1:0] edge_ev;
  logic [NP-1:0][PW-1:0] pin_mask;
  logic                  any_flag;

  ////////////////////////////////////////////////////////////////////////////
  // Port index of a register address, or NP when not a port register
  function automatic int port_of(input logic [4:0] a);
    int p;
    p = NP;
    if (a < pin_change_pkg::IRQ_EN_OFS)
      p = int'(a >> 2);
    return p;
  endfunction

  // Register kind within a port block: 0 rise, 1 fall, 2 flag, 3 none
  function automatic logic [1:0] kind_of(input logic [4:0] a);
    return a[1:0] - pin_change_pkg::RISE_A_OFS[1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin grouping; absent port E pins tie low and are masked off
  assign pins_all[0] = port_a_pins;
  assign pins_all[1] = port_b_pins;
  assign pins_all[2] = port_c_pins;
  assign pins_all[3] = {4'h0, port_e_pins};
  assign pin_mask[0] = pin_change_pkg::PORT_A_MASK;  // [R1]
  assign pin_mask[1] = pin_change_pkg::PORT_B_MASK;  // [R1]
  assign pin_mask[2] = pin_change_pkg::PORT_C_MASK;  // [R1]
  assign pin_mask[3] = pin_change_pkg::PORT_E_MASK;  // [R1]

  ////////////////////////////////////////////////////////////////////////////
  // One synchroniser per port
  genvar g;
  generate
    for (g = 0; g < NP; g++)
    begin : gen_sync
      pin_edge_sync #(
        .W (PW)
      ) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clr     (st_r.unit_dis),
        .pin_in  (pins_all[g]),
        .rise    (rise_ev[g]),
        .fall    (fall_ev[g])
      );
      // Each direction gated by its own enable; both set flags either
      assign edge_ev[g] = pin_mask[g] &
                          ((rise_ev[g] & st_r.rise_enable_reg[g]) |   // [R5] [R6] [R8]
                           (fall_ev[g] & st_r.fall_enable_reg[g]));   // [R5] [R7] [R8]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, flag update and read capture
  always_comb
  begin
    int p;
    logic [1:0] k;
    p      = port_of(reg_addr);
    k      = kind_of(reg_addr);
    st_nxt = st_r;
    // Disabled unit ignores writes except to its own disable bit
    if (reg_wr && !st_r.unit_dis && p < NP)
    begin
      case (k)
        2'd0: st_nxt.rise_enable_reg[p] = reg_wdata & pin_mask[p];
        2'd1: st_nxt.fall_enable_reg[p] = reg_wdata & pin_mask[p];
        2'd2: st_nxt.change_flag_reg[p] = st_r.change_flag_reg[p] & reg_wdata;  // [R11]
        default: ;
      endcase
    end
    if (reg_wr && !st_r.unit_dis && reg_addr == pin_change_pkg::IRQ_EN_OFS)
      st_nxt.irq_en = reg_wdata[pin_change_pkg::CHANGE_IRQ_EN_BIT];
    if (reg_wr && reg_addr == pin_change_pkg::UNIT_DIS_OFS)
      st_nxt.unit_dis = reg_wdata[pin_change_pkg::UNIT_DISABLE_BIT];
    // Edge set wins over a clearing write in the same cycle
    for (int i = 0; i < NP; i++)
      st_nxt.change_flag_reg[i] = st_nxt.change_flag_reg[i] | edge_ev[i];  // [R9] [R12] [R4]
    // Disable holds every control and flag at reset value from the very
    // edge that sets it, so no stale request outlives the disabling write
    if (st_nxt.unit_dis)
    begin
      st_nxt.rise_enable_reg = '0;  // [R15]
      st_nxt.fall_enable_reg = '0;  // [R15]
      st_nxt.change_flag_reg = '0;  // [R15]
      st_nxt.irq_en          = 1'b0;  // [R15]
    end
    // Read data held for exactly the cycle after the strobe
    st_nxt.rdata = pin_change_pkg::REG_RST;
    if (reg_rd)
    begin
      if (p < NP && !st_r.unit_dis)
      begin
        case (k)
          2'd0: st_nxt.rdata = st_r.rise_enable_reg[p];
          2'd1: st_nxt.rdata = st_r.fall_enable_reg[p];
          2'd2: st_nxt.rdata = st_r.change_flag_reg[p];
          default: st_nxt.rdata = pin_change_pkg::REG_RST;
        endcase
      end
      else if (reg_addr == pin_change_pkg::IRQ_EN_OFS)
        st_nxt.rdata[pin_change_pkg::CHANGE_IRQ_EN_BIT] = st_r.irq_en;
      else if (reg_addr == pin_change_pkg::IRQ_FLAG_OFS)
        st_nxt.rdata[pin_change_pkg::CHANGE_SUMMARY_BIT] = any_flag;
      else if (reg_addr == pin_change_pkg::UNIT_DIS_OFS)
        st_nxt.rdata[pin_change_pkg::UNIT_DISABLE_BIT] = st_r.unit_dis;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Summary and interrupt; any one pin flag suffices
  assign any_flag            = |st_r.change_flag_reg;  // [R10] [R2]
  assign change_summary_flag = any_flag;  // [R10]
  assign change_irq_enable   = st_r.irq_en;
  assign change_irq          = any_flag && st_r.irq_en;  // [R3] [R4] [R9]
  // Wake only while asleep and the master enable allows it
  assign wake_req            = sleep_mode && any_flag && st_r.irq_en;  // [R14]
  assign reg_rdata           = st_r.rdata;

endmodule

// *** design/pin_change_pkg.sv ***
// Function
// R1: Change detection on all pins of ports A, B, C and low four of E.
// R2: Any pin or combination of pins may cause the change interrupt.
// R3: Interrupt raised only while master change enable bit is set.
// R4: With master enable clear, edges still set flags but no interrupt.
// R5: Each pin has independent rising and falling edge detectors.
// R6: Rising detection active only while its rise enable bit is set.
// R7: Falling detection active only while its fall enable bit is set.
// R8: Both enables set means either edge direction is flagged.
// R9: Enabled edge sets the pin flag, and interrupts if master enabled.
// R10: Summary flag is the OR of every per-pin flag bit.
// R11: Writing zero to a flag bit clears that flag.
// R12: An edge during a flag write leaves the flag set regardless.
// R13: Software should clear only known set bits by AND masking.
// R14: A change event wakes the device from sleep if master enabled.
// R15: Unit disable bit holds all change logic in reset; the pin synchronisers keep sampling the pins instead.
// R16: Pins synchronised; edges found by comparing current and previous sample.
package pin_change_pkg;

  localparam int NUM_PORTS  = 4;
  localparam int PORT_W     = 8;
  localparam int ADDR_W     = 5;
  localparam int SYNC_DEPTH = 3;

  // Pins present per port: A, B, C full, E low four
  localparam logic [7:0] PORT_A_MASK = 8'hff;
  localparam logic [7:0] PORT_B_MASK = 8'hff;
  localparam logic [7:0] PORT_C_MASK = 8'hff;
  localparam logic [7:0] PORT_E_MASK = 8'h0f;

  // Register offsets: three per port, then the shared control registers
  localparam logic [4:0] RISE_A_OFS    = 5'h00;
  localparam logic [4:0] FALL_A_OFS    = 5'h01;
  localparam logic [4:0] FLAG_A_OFS    = 5'h02;
  localparam logic [4:0] PORT_STRIDE   = 5'h04;
  localparam logic [4:0] IRQ_EN_OFS    = 5'h10;
  localparam logic [4:0] IRQ_FLAG_OFS  = 5'h11;
  localparam logic [4:0] UNIT_DIS_OFS  = 5'h12;

  // Field positions
  localparam int CHANGE_IRQ_EN_BIT  = 4;
  localparam int CHANGE_SUMMARY_BIT = 4;
  localparam int UNIT_DISABLE_BIT   = 0;

  // Reset values
  localparam logic [7:0] REG_RST = 8'h00;

endpackage

// *** design/pin_edge_sync.sv ***
`timescale 1ns/1ns
// Three-stage synchroniser and edge detector for a group of pins
module pin_edge_sync #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,   // System clock
  input  wire logic         rst,       // Async reset, active high
  input  wire logic         clr,       // Synchronous disarm; pins still tracked, no edges
  input  wire logic [W-1:0] pin_in,    // Raw pins
  output logic      [W-1:0] rise,      // Rising edge pulse
  output logic      [W-1:0] fall       // Falling edge pulse
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] prev;
    logic         armed;
  } sync_t;

  sync_t st_r;
  sync_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Stage one feeds only stage two; a level counts once stages two and
  // three agree, so prev holds the last agreed value
  always_comb
  begin
    st_nxt    = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++)
    begin
      if (st_r.s2[i] == st_r.s3[i])
        st_nxt.prev[i] = st_r.s3[i];  // [R16]
    end
    st_nxt.armed = 1'b1;
    // Disabled unit relearns the pin level without flagging edges
    if (clr)
    begin
      st_nxt.prev  = st_r.s3;
      st_nxt.armed = 1'b0;  // [R15]
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge = agreed new level differs from previous agreed level
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      rise[i] = st_r.armed && !clr && (st_r.s2[i] == st_r.s3[i])
                && st_r.s3[i] && !st_r.prev[i];  // [R16]
      fall[i] = st_r.armed && !clr && (st_r.s2[i] == st_r.s3[i])
                && !st_r.s3[i] && st_r.prev[i];  // [R16]
    end
  end

endmodule

// *** test/pin_change_sva.sv ***
`timescale 1ns/1ns
// Port-level checks of the change unit
module pin_change_sva (
  input wire logic       sys_clk,              // Clock
  input wire logic       rst,                  // Reset
  input wire logic [7:0] port_a_pins,          // Pins
  input wire logic [7:0] port_b_pins,          // Pins
  input wire logic [7:0] port_c_pins,          // Pins
  input wire logic [3:0] port_e_pins,          // Pins
  input wire logic       sleep_mode,           // Asleep
  input wire logic [4:0] reg_addr,             // Address
  input wire logic [7:0] reg_wdata,            // Write data
  input wire logic       reg_wr,               // Write
  input wire logic       reg_rd,               // Read
  input wire logic [7:0] reg_rdata,            // Read data
  input wire logic       change_irq,           // Interrupt
  input wire logic       wake_req,             // Wake
  input wire logic       change_summary_flag,  // Summary
  input wire logic       change_irq_enable     // Master enable
);
  logic        dis_r;   // Unit disable as software wrote it
  logic [27:0] pins_q;  // Last pin sample
  logic [2:0]  age_r;   // Cycles since pins last moved, saturating
  ////////////////////////////////////////////////////////////////////////
  // Tracking kept here so flag rises can be tied to a real pin change
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dis_r  <= 1'b0;
      pins_q <= 28'h0;
      age_r  <= 3'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == pin_change_pkg::UNIT_DIS_OFS) dis_r <= reg_wdata[0];
      pins_q <= {port_a_pins, port_b_pins, port_c_pins, port_e_pins};
      if (pins_q != {port_a_pins, port_b_pins, port_c_pins, port_e_pins}) age_r <= 3'h0;
      else if (age_r != 3'h7) age_r <= age_r + 3'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_irq_gate; change_irq |-> change_irq_enable; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
  property p_irq_set; change_summary_flag && change_irq_enable |-> change_irq; endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq missing");
  property p_wake; wake_req == (change_irq && sleep_mode); endproperty
  a_wake: assert property (p_wake) else $error("wake wrong");
  property p_en_write;
    reg_wr && reg_addr == pin_change_pkg::IRQ_EN_OFS && !dis_r
      |=> change_irq_enable == $past(reg_wdata[pin_change_pkg::CHANGE_IRQ_EN_BIT]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable not written");
  property p_dis; dis_r |-> !change_irq_enable && !change_summary_flag; endproperty
  a_dis: assert property (p_dis) else $error("active while disabled");
  property p_sticky; $fell(change_summary_flag) |-> $past(reg_wr); endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  property p_age; $rose(change_summary_flag) |-> age_r >= 3'h1 && age_r <= 3'h5; endproperty
  a_age: assert property (p_age) else $error("flag without pin edge");
  property p_sum_rd;
    reg_rd && reg_addr == pin_change_pkg::IRQ_FLAG_OFS
      |=> reg_rdata[pin_change_pkg::CHANGE_SUMMARY_BIT] == $past(change_summary_flag);
  endproperty
  a_sum_rd: assert property (p_sum_rd) else $error("summary read wrong");
endmodule

bind pin_change_interrupt pin_change_sva chk_u (.sys_clk, .rst, .port_a_pins, .port_b_pins,
  .port_c_pins, .port_e_pins, .sleep_mode, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .change_irq, .wake_req, .change_summary_flag, .change_irq_enable);

// *** test/pin_source.sv ***
`timescale 1ns/1ns
// External drivers on the port pins; levels move just after an edge
module pin_source (
  input  wire logic       sys_clk,      // Clock
  output logic      [7:0] port_a_pins,  // Port A
  output logic      [7:0] port_b_pins,  // Port B
  output logic      [7:0] port_c_pins,  // Port C
  output logic      [3:0] port_e_pins   // Port E low
);
  initial
  begin
    {port_a_pins, port_b_pins, port_c_pins, port_e_pins} = 28'h0;
  end
  // Caller holds each level for several cycles so the synchroniser sees it
  task automatic set_port(input int p, input logic [7:0] v);
    @(posedge sys_clk);
    case (p)
      0: port_a_pins <= v;
      1: port_b_pins <= v;
      2: port_c_pins <= v;
      default: port_e_pins <= v[3:0];
    endcase
  endtask
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ns
`define CHK(g, e) begin #1; tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  logic       sys_clk, rst, sleep_mode, reg_wr, reg_rd, change_irq, wake_req;
  logic       change_summary_flag, change_irq_enable;
  logic [4:0] reg_addr, a;
  logic [7:0] reg_wdata, reg_rdata, m;
  wire  [7:0] pa, pb, pc;
  wire  [3:0] pe;
  int         miscompares, tests_run;
  always #5 sys_clk = ~sys_clk;
  pin_source pins_u (.sys_clk(sys_clk), .port_a_pins(pa), .port_b_pins(pb),
    .port_c_pins(pc), .port_e_pins(pe));
  pin_change_interrupt dut_u (.sys_clk(sys_clk), .rst(rst), .port_a_pins(pa),
    .port_b_pins(pb), .port_c_pins(pc), .port_e_pins(pe), .sleep_mode(sleep_mode),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .change_irq(change_irq), .wake_req(wake_req),
    .change_summary_flag(change_summary_flag), .change_irq_enable(change_irq_enable));
  ////////////////////////////////////////////////////////////////////////
  // Single-cycle strobes; read data is taken in the cycle after the strobe
  task automatic wr(input logic [4:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, ad, d};
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic chk(input logic [4:0] ad, input logic [7:0] e);
    @(posedge sys_clk);
    {reg_rd, reg_addr} <= {1'b1, ad};
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    `CHK(reg_rdata, e)
  endtask
  task automatic print_verdict;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {sys_clk, rst} = 2'b01;
    {sleep_mode, reg_wr, reg_rd, reg_addr, reg_wdata} = 16'h0;
    {miscompares, tests_run} = 0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    chk(5'h00, 8'h00);
    chk(5'h1f, 8'h00);
    // Each port: rise on 0x55 pins, fall on 0x33, Port E only four pins wide
    for (int p = 0; p < 4; p++)
    begin
      a = 5'(4 * p);
      m = (p == 3) ? pin_change_pkg::PORT_E_MASK : 8'hff;
      wr(a, 8'h55);
      wr(a + 5'h01, 8'h33);
      pins_u.set_port(p, 8'hff);
      repeat (6) @(posedge sys_clk);
      chk(a + 5'h02, 8'h55 & m);
      chk(pin_change_pkg::IRQ_FLAG_OFS, 8'h10);
      `CHK(change_irq, 1'b0)
      pins_u.set_port(p, 8'h00);
      repeat (6) @(posedge sys_clk);
      chk(a + 5'h02, 8'h77 & m);
      wr(a + 5'h02, ~(8'h77 & m));
      chk(a + 5'h02, 8'h00);
    end
    // Master enable gates the request but not the flag
    pins_u.set_port(0, 8'h01);
    repeat (6) @(posedge sys_clk);
    `CHK(change_irq, 1'b0)
    wr(pin_change_pkg::IRQ_EN_OFS, 8'h10);
    `CHK(change_irq, 1'b1)
    @(posedge sys_clk) sleep_mode <= 1'b1;
    @(posedge sys_clk);
    `CHK(wake_req, 1'b1)
    // Clearing write lands on the very edge that sets bit 2, four edges
    // after the pin moves; bit 2 is rise enabled, bit 0 is cleared
    pins_u.set_port(0, 8'h05);
    repeat (2) @(posedge sys_clk);
    wr(pin_change_pkg::FLAG_A_OFS, 8'h00);
    chk(pin_change_pkg::FLAG_A_OFS, 8'h04);
    // Disabled unit ignores writes and pins, comes back in reset state
    wr(pin_change_pkg::UNIT_DIS_OFS, 8'h01);
    `CHK({change_irq_enable, change_summary_flag}, 2'b00)
    wr(pin_change_pkg::RISE_A_OFS, 8'hff);
    pins_u.set_port(0, 8'h00);
    repeat (6) @(posedge sys_clk);
    wr(pin_change_pkg::UNIT_DIS_OFS, 8'h00);
    chk(pin_change_pkg::RISE_A_OFS, 8'h00);
    chk(pin_change_pkg::FLAG_A_OFS, 8'h00);
    print_verdict;
  end
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    print_verdict;
  end
endmodule
